// *** src/ccfie_defines.svh ***
// Constants for the CPU cycle, flag and interrupt enable block
`ifndef CCFIE_DEFINES_SVH
`define CCFIE_DEFINES_SVH
`define CCFIE_DIV_XTAL      2'd2
`define CCFIE_DIV_RC        2'd1
`define CCFIE_ACC_RST       4'h0
`define CCFIE_FLAG_RST      1'b0
`define CCFIE_MIE_RST       1'b0
`define CCFIE_MIE_BIT       0
`define CCFIE_MIE_REG_W     4
`define CCFIE_STK_DEPTH     16
`define CCFIE_STK_AW        4
`define CCFIE_STK_W         7
`define CCFIE_MAX_CYCLES    2'd3
`define CCFIE_IRQ_N         8
`define CCFIE_WDT_IDX       0
`endif

// *** src/ccfie_pkg.sv ***
// Types for the CPU cycle, flag and interrupt enable block
package ccfie_pkg;
  typedef enum logic [3:0] {
    ST_S1L = 4'h1,
    ST_S1H = 4'h2,
    ST_S2L = 4'h4,
    ST_S2H = 4'h8
  } ccfie_state_t;

  typedef enum logic [3:0] {
    OP_NOP  = 4'h0,
    OP_ADD  = 4'h1,
    OP_SUB  = 4'h2,
    OP_LOAD = 4'h3,
    OP_SWAP = 4'h4,
    OP_PIN  = 4'h5,
    OP_POUT = 4'h6,
    OP_PUSH = 4'h7,
    OP_POP  = 4'h8,
    OP_EI   = 4'h9,
    OP_DI   = 4'ha,
    OP_RTI  = 4'hb
  } ccfie_op_t;
endpackage : ccfie_pkg

// *** src/ccfie_regstack.sv ***
// Register stack for accumulator and flags, with its up/down pointer
`timescale 1ns/10ps
`include "ccfie_defines.svh"
module ccfie_regstack #(
  parameter int W     = `CCFIE_STK_W,
  parameter int DEPTH = `CCFIE_STK_DEPTH,
  parameter int AW    = `CCFIE_STK_AW
) (
  // Clock and reset
  input  wire logic          mclk_i,
  input  wire logic          nrst_i,
  // Push and pop
  input  wire logic          push_i,
  input  wire logic          pop_i,
  input  wire logic [W-1:0]  data_i,
  output logic      [W-1:0]  data_o,
  output logic      [AW-1:0] rsp_o
);
  logic [W-1:0]  mem_r   [DEPTH];
  logic [W-1:0]  mem_nxt [DEPTH];
  logic [AW-1:0] rsp_r;
  logic [AW-1:0] rsp_nxt;
  logic [W-1:0]  out_r;
  logic [W-1:0]  out_nxt;

  always_comb begin
    rsp_nxt = rsp_r;
    out_nxt = out_r;
    if (push_i) begin
      rsp_nxt = rsp_r + 1'b1;
    end else if (pop_i) begin
      rsp_nxt = rsp_r - 1'b1;
      out_nxt = mem_r[rsp_r - 1'b1];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_entry
      always_comb begin
        mem_nxt[gi] = mem_r[gi];
        if (push_i && rsp_r == AW'(gi)) begin
          mem_nxt[gi] = data_i;
        end
      end
      always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          mem_r[gi] <= '0;
        end else begin
          mem_r[gi] <= mem_nxt[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsp_r <= '0;
      out_r <= '0;
    end else begin
      rsp_r <= rsp_nxt;
      out_r <= out_nxt;
    end
  end

  assign data_o = out_nxt;
  assign rsp_o  = rsp_r;
endmodule : ccfie_regstack

// *** src/ccfie_core.sv ***
// CPU machine cycle sequencer, accumulator, flags and global interrupt enable
// Behaviour
// - Machine cycle is two states, each from one system clock falling edge to the next.
// - Instructions take one to three whole machine cycles.
// - System clock from oscillator; crystal halved, RC undivided, in phase.
// - Port write drives new pin value at the rising edge inside the second state.
// - Port read samples while clock high in first state; accumulator loads next cycle.
// - Any low during the capture window latches zero; one needs high throughout.
// - Interrupt sources sampled on falling edge; request set in first half of first state.
// - Accepted interrupt starts its service routine in the next machine cycle.
// - Accumulator clears to zero on reset.
// - Primary pointer push saves accumulator on register stack; pop restores it.
// - Carry, zero and overflow flags are saved and restored with the accumulator.
// - Carry takes add carry or subtract borrow; clears on reset.
// - Zero flag follows accumulator loads of zero; swap leaves it; reset clears.
// - Overflow flag sets when a pointer wraps; reset clears it.
// - Global enable is bit 0 of a 4-bit register; zero blocks all but watchdog.
// - Accepting any interrupt clears the enable; return from handler sets it.
// - Global enable is zero after reset.
// - Enable register is read-only; only enable, mask and return instructions and interrupt accept change it.
// - Register stack pointer is a 4-bit counter, up on push, down on pop.
`timescale 1ns/10ps
`include "ccfie_defines.svh"
module ccfie_core #(
  parameter int IRQ_N   = `CCFIE_IRQ_N,
  parameter int WDT_IDX = `CCFIE_WDT_IDX
) (
  // Clock and reset
  input  wire logic                       mclk_i,
  input  wire logic                       nrst_i,
  // Oscillator source: 1 selects RC, 0 crystal
  input  wire logic                       osc_rc_i,
  output logic                            sysclk_o,
  output logic                            cycle_start_o,
  output logic [3:0]                      state_o,
  // Instruction issue
  input  wire logic                       instr_valid_i,
  input  wire ccfie_pkg::ccfie_op_t       instr_op_i,
  input  wire logic [1:0]                 instr_cycles_i,
  input  wire logic [3:0]                 instr_data_i,
  output logic                            instr_ack_o,
  output logic [3:0]                      swap_data_o,
  // Pointer wrap from pointer logic
  input  wire logic                       ptr_wrap_i,
  // Port pins
  input  wire logic [3:0]                 port_pin_i,
  output logic [3:0]                      port_out_o,
  // Interrupts
  input  wire logic [IRQ_N-1:0]           irq_src_i,
  output logic                            irq_ack_o,
  output logic [$clog2(IRQ_N)-1:0]        irq_id_o,
  // Status
  output logic [3:0]                      acc_o,
  output logic                            carry_o,
  output logic                            zero_o,
  output logic                            ovf_o,
  output logic [`CCFIE_MIE_REG_W-1:0]     global_irq_enable_reg_o,
  output logic [`CCFIE_STK_AW-1:0]        rsp_o
);
  localparam int IW = $clog2(IRQ_N);

  // Timing group
  ccfie_pkg::ccfie_state_t state_r, state_nxt;
  logic       div_r, div_nxt;
  logic [1:0] rc_sync_r, rc_sync_nxt;
  logic [3:0] pin_s1_r, pin_s2_r;
  logic [1:0] div_max;
  logic       tick;
  logic       bnd;

  assign div_max = rc_sync_r[1] ? `CCFIE_DIV_RC : `CCFIE_DIV_XTAL;
  assign tick    = (div_max == `CCFIE_DIV_RC) || div_r;
  assign bnd     = tick && (state_r == ccfie_pkg::ST_S2H);

  always_comb begin
    div_nxt     = rc_sync_r[1] ? 1'b0 : ~div_r;
    rc_sync_nxt = {rc_sync_r[0], osc_rc_i};
    state_nxt   = state_r;
    if (tick) begin
      case (state_r)
        ccfie_pkg::ST_S1L: state_nxt = ccfie_pkg::ST_S1H;
        ccfie_pkg::ST_S1H: state_nxt = ccfie_pkg::ST_S2L;
        ccfie_pkg::ST_S2L: state_nxt = ccfie_pkg::ST_S2H;
        ccfie_pkg::ST_S2H: state_nxt = ccfie_pkg::ST_S1L;
        default:           state_nxt = ccfie_pkg::ST_S1L;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r   <= ccfie_pkg::ST_S1L;
      div_r     <= 1'b0;
      rc_sync_r <= 2'h0;
      pin_s1_r  <= 4'hf;
      pin_s2_r  <= 4'hf;
    end else begin
      state_r   <= state_nxt;
      div_r     <= div_nxt;
      rc_sync_r <= rc_sync_nxt;
      pin_s1_r  <= port_pin_i;
      pin_s2_r  <= pin_s1_r;
    end
  end

  assign sysclk_o      = (state_r == ccfie_pkg::ST_S1H) || (state_r == ccfie_pkg::ST_S2H);
  assign state_o       = state_r;
  assign cycle_start_o = bnd;

  // Core group
  ccfie_pkg::ccfie_op_t op_r, op_nxt;
  logic [3:0]    acc_r, acc_nxt, opd_r, opd_nxt, cap_r, cap_nxt;
  logic [3:0]    pout_r, pout_nxt, swp_r, swp_nxt;
  logic          c_r, c_nxt, z_r, z_nxt, g_r, g_nxt, mie_r, mie_nxt;
  logic          busy_r, busy_nxt, ack_r, ack_nxt;
  logic [1:0]    cyc_r, cyc_nxt;
  logic [IRQ_N-1:0] req_r, req_nxt, pend, req_clr;
  logic [IW-1:0] id_r, id_nxt, pick;
  logic          done, commit, accept, push, pop;
  logic [4:0]    sum;
  logic [6:0]    stk_out;

  assign done   = !busy_r || (cyc_r == 2'd1);
  assign commit = bnd && busy_r && (cyc_r == 2'd1);
  assign pend   = mie_r ? req_r : (req_r & (IRQ_N'(1) << WDT_IDX));
  assign accept = bnd && done && (pend != '0);
  assign push   = commit && (op_r == ccfie_pkg::OP_PUSH);
  assign pop    = commit && (op_r == ccfie_pkg::OP_POP);
  assign instr_ack_o = bnd && done && !accept && instr_valid_i;

  always_comb begin
    pick = '0;
    for (int i = IRQ_N - 1; i >= 0; i--) begin
      if (pend[i]) begin
        pick = IW'(i);
      end
    end
  end

  always_comb begin
    acc_nxt  = acc_r;
    c_nxt    = c_r;
    z_nxt    = z_r;
    g_nxt    = g_r;
    mie_nxt  = mie_r;
    op_nxt   = op_r;
    opd_nxt  = opd_r;
    cyc_nxt  = cyc_r;
    busy_nxt = busy_r;
    pout_nxt = pout_r;
    swp_nxt  = swp_r;
    cap_nxt  = cap_r;
    id_nxt   = id_r;
    ack_nxt  = 1'b0;
    req_clr  = '0;
    sum      = 5'h00;
    if (tick && state_r == ccfie_pkg::ST_S1L) begin
      cap_nxt = pin_s2_r;
    end else if (state_r == ccfie_pkg::ST_S1H) begin
      cap_nxt = cap_r & pin_s2_r;
    end
    if (tick && state_r == ccfie_pkg::ST_S2L && busy_r && op_r == ccfie_pkg::OP_POUT) begin
      pout_nxt = opd_r;
    end
    if (commit) begin
      case (op_r)
        ccfie_pkg::OP_ADD: begin
          sum     = {1'b0, acc_r} + {1'b0, opd_r};
          acc_nxt = sum[3:0];
          c_nxt   = sum[4];
          z_nxt   = (sum[3:0] == 4'h0);
        end
        ccfie_pkg::OP_SUB: begin
          sum     = {1'b0, acc_r} - {1'b0, opd_r};
          acc_nxt = sum[3:0];
          c_nxt   = sum[4];
          z_nxt   = (sum[3:0] == 4'h0);
        end
        ccfie_pkg::OP_LOAD: begin
          acc_nxt = opd_r;
          z_nxt   = (opd_r == 4'h0);
        end
        ccfie_pkg::OP_SWAP: begin
          swp_nxt = acc_r;
          acc_nxt = opd_r;
        end
        ccfie_pkg::OP_PIN: begin
          acc_nxt = cap_r;
          z_nxt   = (cap_r == 4'h0);
        end
        ccfie_pkg::OP_POP: begin
          {g_nxt, c_nxt, z_nxt, acc_nxt} = stk_out;
        end
        ccfie_pkg::OP_EI:  mie_nxt = 1'b1;
        ccfie_pkg::OP_DI:  mie_nxt = 1'b0;
        ccfie_pkg::OP_RTI: mie_nxt = 1'b1;
        default: ;
      endcase
    end
    if (ptr_wrap_i) begin
      g_nxt = 1'b1;
    end
    if (bnd) begin
      if (accept) begin
        mie_nxt  = 1'b0;
        id_nxt   = pick;
        ack_nxt  = 1'b1;
        req_clr[pick] = 1'b1;
        busy_nxt = 1'b0;
        cyc_nxt  = 2'd0;
        op_nxt   = ccfie_pkg::OP_NOP;
      end else if (done) begin
        busy_nxt = instr_valid_i;
        op_nxt   = instr_valid_i ? instr_op_i : ccfie_pkg::OP_NOP;
        opd_nxt  = instr_data_i;
        cyc_nxt  = (instr_cycles_i == 2'd0) ? 2'd1 : instr_cycles_i;
      end else begin
        cyc_nxt = cyc_r - 2'd1;
      end
    end
    req_nxt = req_r & ~req_clr;
    if (tick && state_r == ccfie_pkg::ST_S2H) begin
      req_nxt = req_nxt | irq_src_i;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_r  <= `CCFIE_ACC_RST;
      c_r    <= `CCFIE_FLAG_RST;
      z_r    <= `CCFIE_FLAG_RST;
      g_r    <= `CCFIE_FLAG_RST;
      mie_r  <= `CCFIE_MIE_RST;
      op_r   <= ccfie_pkg::OP_NOP;
      opd_r  <= 4'h0;
      cyc_r  <= 2'd0;
      busy_r <= 1'b0;
      pout_r <= 4'h0;
      swp_r  <= 4'h0;
      cap_r  <= 4'hf;
      id_r   <= '0;
      ack_r  <= 1'b0;
      req_r  <= '0;
    end else begin
      acc_r  <= acc_nxt;
      c_r    <= c_nxt;
      z_r    <= z_nxt;
      g_r    <= g_nxt;
      mie_r  <= mie_nxt;
      op_r   <= op_nxt;
      opd_r  <= opd_nxt;
      cyc_r  <= cyc_nxt;
      busy_r <= busy_nxt;
      pout_r <= pout_nxt;
      swp_r  <= swp_nxt;
      cap_r  <= cap_nxt;
      id_r   <= id_nxt;
      ack_r  <= ack_nxt;
      req_r  <= req_nxt;
    end
  end

  ccfie_regstack u_regstack (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .push_i (push),
    .pop_i  (pop),
    .data_i ({g_r, c_r, z_r, acc_r}),
    .data_o (stk_out),
    .rsp_o  (rsp_o)
  );

  assign acc_o       = acc_r;
  assign carry_o     = c_r;
  assign zero_o      = z_r;
  assign ovf_o       = g_r;
  assign port_out_o  = pout_r;
  assign swap_data_o = swp_r;
  assign irq_ack_o   = ack_r;
  assign irq_id_o    = id_r;
  assign global_irq_enable_reg_o = {3'h0, mie_r};

  // Checks
  property p_state_walk;
    @(posedge mclk_i) disable iff (!nrst_i)
      (tick && state_r == ccfie_pkg::ST_S2H) |=> (state_r == ccfie_pkg::ST_S1L) ##1 (state_r != ccfie_pkg::ST_S2L);
  endproperty
  a_state_walk: assert property (p_state_walk) else $error("state order broken");

  property p_port_write;
    @(posedge mclk_i) disable iff (!nrst_i)
      (port_out_o != $past(port_out_o)) |-> (state_r == ccfie_pkg::ST_S2H && $past(state_r) == ccfie_pkg::ST_S2L);
  endproperty
  a_port_write: assert property (p_port_write) else $error("port changed outside second state rise");

  property p_pin_load;
    @(posedge mclk_i) disable iff (!nrst_i)
      (commit && op_r == ccfie_pkg::OP_PIN) |=> (acc_o == $past(cap_r) && state_r == ccfie_pkg::ST_S1L);
  endproperty
  a_pin_load: assert property (p_pin_load) else $error("port read not loaded at cycle start");

  property p_capture_low;
    @(posedge mclk_i) disable iff (!nrst_i)
      (state_r == ccfie_pkg::ST_S1H) |=> ((cap_r & ~$past(pin_s2_r)) == 4'h0);
  endproperty
  a_capture_low: assert property (p_capture_low) else $error("low level not captured");

  property p_add;
    @(posedge mclk_i) disable iff (!nrst_i)
      (commit && op_r == ccfie_pkg::OP_ADD) |=> ({carry_o, acc_o} == ({1'b0, $past(acc_r)} + {1'b0, $past(opd_r)}));
  endproperty
  a_add: assert property (p_add) else $error("add result or carry wrong");

  property p_zero;
    @(posedge mclk_i) disable iff (!nrst_i)
      (commit && (op_r == ccfie_pkg::OP_LOAD || op_r == ccfie_pkg::OP_SUB)) |=> (zero_o == (acc_o == 4'h0));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag does not follow load");

  property p_swap_zero;
    @(posedge mclk_i) disable iff (!nrst_i)
      (commit && op_r == ccfie_pkg::OP_SWAP) |=> $stable(zero_o);
  endproperty
  a_swap_zero: assert property (p_swap_zero) else $error("swap changed zero flag");

  property p_wrap;
    @(posedge mclk_i) disable iff (!nrst_i)
      ptr_wrap_i |=> ovf_o;
  endproperty
  a_wrap: assert property (p_wrap) else $error("overflow flag missed wrap");

  property p_accept_clears;
    @(posedge mclk_i) disable iff (!nrst_i)
      irq_ack_o |-> (!global_irq_enable_reg_o[`CCFIE_MIE_BIT] && $past(bnd) && state_r == ccfie_pkg::ST_S1L);
  endproperty
  a_accept_clears: assert property (p_accept_clears) else $error("accept did not clear enable");

  property p_gate;
    @(posedge mclk_i) disable iff (!nrst_i)
      irq_ack_o |-> ($past(mie_r) || irq_id_o == IW'(WDT_IDX));
  endproperty
  a_gate: assert property (p_gate) else $error("interrupt taken while blocked");

  property p_rti;
    @(posedge mclk_i) disable iff (!nrst_i)
      (commit && op_r == ccfie_pkg::OP_RTI && !accept) |=> global_irq_enable_reg_o == 4'h1;
  endproperty
  a_rti: assert property (p_rti) else $error("return did not set enable");

  property p_push_rsp;
    @(posedge mclk_i) disable iff (!nrst_i)
      push |=> (rsp_o == $past(rsp_o) + 4'h1);
  endproperty
  a_push_rsp: assert property (p_push_rsp) else $error("stack pointer did not count up");

  c_irq:  cover property (@(posedge mclk_i) disable iff (!nrst_i) irq_ack_o);
  c_pin:  cover property (@(posedge mclk_i) disable iff (!nrst_i) commit && op_r == ccfie_pkg::OP_PIN);
  c_pop:  cover property (@(posedge mclk_i) disable iff (!nrst_i) pop);
  c_long: cover property (@(posedge mclk_i) disable iff (!nrst_i) commit && op_r != ccfie_pkg::OP_NOP && $past(cyc_r) == 2'd2);
endmodule : ccfie_core

// *** verif/ccfie_core_tb.sv ***
// Self-checking testbench for the CPU cycle, flag and interrupt enable block
`timescale 1ns/10ps
module ccfie_core_tb;
  logic                 mclk_i         = 1'b0;
  logic                 nrst_i         = 1'b0;
  logic                 osc_rc_i       = 1'b0;
  logic                 instr_valid_i  = 1'b0;
  ccfie_pkg::ccfie_op_t instr_op_i     = ccfie_pkg::OP_NOP;
  logic [1:0]           instr_cycles_i = 2'h1;
  logic [3:0]           instr_data_i   = 4'h0;
  logic                 ptr_wrap_i     = 1'b0;
  logic [3:0]           port_pin_i     = 4'hf;
  logic [7:0]           irq_src_i      = 8'h00;
  logic                 sysclk_o, cycle_start_o, instr_ack_o, irq_ack_o, carry_o, zero_o, ovf_o;
  logic [3:0]           state_o, swap_data_o, port_out_o, acc_o, global_irq_enable_reg_o, rsp_o;
  logic [2:0]           irq_id_o;
  int                   n_fail    = 0;
  int                   tests_run = 0;
  int                   n_ack     = 0;
  int                   cyc       = 0;
  int                   i;
  time                  t0, t1;

  ccfie_core #(.IRQ_N(8), .WDT_IDX(0)) DUT (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .osc_rc_i(osc_rc_i), .sysclk_o(sysclk_o),
    .cycle_start_o(cycle_start_o), .state_o(state_o), .instr_valid_i(instr_valid_i),
    .instr_op_i(instr_op_i), .instr_cycles_i(instr_cycles_i), .instr_data_i(instr_data_i),
    .instr_ack_o(instr_ack_o), .swap_data_o(swap_data_o), .ptr_wrap_i(ptr_wrap_i),
    .port_pin_i(port_pin_i), .port_out_o(port_out_o), .irq_src_i(irq_src_i), .irq_ack_o(irq_ack_o),
    .irq_id_o(irq_id_o), .acc_o(acc_o), .carry_o(carry_o), .zero_o(zero_o), .ovf_o(ovf_o),
    .global_irq_enable_reg_o(global_irq_enable_reg_o), .rsp_o(rsp_o)
  );

  always #50 mclk_i = ~mclk_i;

  always @(negedge mclk_i) begin
    if (irq_ack_o === 1'b1)
      n_ack++;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // Run needs several hundred cycles; the ceiling leaves ample margin
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Offer one instruction and hold it until the boundary that takes it
  task automatic issue(input ccfie_pkg::ccfie_op_t op, input logic [3:0] d, input logic [1:0] c, output time t);
    int k;
    @(posedge mclk_i);
    instr_valid_i  <= 1'b1;
    instr_op_i     <= op;
    instr_data_i   <= d;
    instr_cycles_i <= c;
    @(negedge mclk_i);
    for (k = 0; k < 80 && instr_ack_o !== 1'b1; k++) @(negedge mclk_i);
    chk("instr ack", 8'h01, instr_ack_o);
    @(posedge mclk_i);
    t = $time;
    instr_valid_i <= 1'b0;
  endtask : issue

  task automatic wait_bnd();
    int k;
    @(negedge mclk_i);
    for (k = 0; k < 40 && cycle_start_o !== 1'b1; k++) @(negedge mclk_i);
  endtask : wait_bnd

  // Let the commit boundary of the last cycle pass, then sample
  task automatic settle(input int c);
    repeat (c) wait_bnd();
    @(posedge mclk_i);
    @(posedge mclk_i);
    @(negedge mclk_i);
  endtask : settle

  task automatic exec(input ccfie_pkg::ccfie_op_t op, input logic [3:0] d, input logic [1:0] c);
    time t;
    issue(op, d, c, t);
    settle(c);
  endtask : exec

  // Hold a source across one boundary so that the falling edge samples it
  task automatic pulse(input logic [7:0] m);
    @(posedge mclk_i);
    irq_src_i <= m;
    wait_bnd();
    @(posedge mclk_i);
    irq_src_i <= 8'h00;
  endtask : pulse

  task automatic wait_irq(input logic [2:0] id);
    int k;
    @(negedge mclk_i);
    for (k = 0; k < 40 && irq_ack_o !== 1'b1; k++) @(negedge mclk_i);
    chk("irq ack", 8'h01, irq_ack_o);
    chk("irq id", {5'h00, id}, irq_id_o);
    @(negedge mclk_i);
    chk("enable after accept", 8'h00, global_irq_enable_reg_o);
  endtask : wait_irq

  // Mclk cycles of one machine cycle and how many of them see the system clock high
  task automatic period(input logic [7:0] exp);
    int n;
    int h;
    wait_bnd();
    n = 0;
    h = 0;
    do begin
      @(negedge mclk_i);
      n++;
      if (sysclk_o === 1'b1)
        h++;
    end while (cycle_start_o !== 1'b1 && n < 40);
    chk("cycle length", exp, 8'(n));
    chk("sysclk high", exp >> 1, 8'(h));
  endtask : period

  initial begin
    repeat (4) @(posedge mclk_i);
    nrst_i <= 1'b1;
    @(negedge mclk_i);
    chk("acc reset", 8'h00, acc_o);
    chk("carry reset", 8'h00, carry_o);
    chk("zero reset", 8'h00, zero_o);
    chk("ovf reset", 8'h00, ovf_o);
    chk("enable reset", 8'h00, global_irq_enable_reg_o);
    chk("rsp reset", 8'h00, rsp_o);
    period(8'h08);
    for (i = 1; i < 4; i++) begin
      issue(ccfie_pkg::OP_NOP, 4'h0, 2'(i), t0);
      issue(ccfie_pkg::OP_NOP, 4'h0, 2'h1, t1);
      chk("instr spacing", 8'(8 * i), 8'((t1 - t0) / 100));
    end
    settle(1);
    exec(ccfie_pkg::OP_LOAD, 4'h9, 2'h1);
    chk("zero nonzero load", 8'h00, zero_o);
    exec(ccfie_pkg::OP_ADD, 4'hc, 2'h1);
    chk("add acc", 8'h05, acc_o);
    chk("add carry", 8'h01, carry_o);
    exec(ccfie_pkg::OP_SUB, 4'h6, 2'h1);
    chk("sub borrow", 8'h01, carry_o);
    exec(ccfie_pkg::OP_LOAD, 4'h0, 2'h1);
    chk("zero on load", 8'h01, zero_o);
    exec(ccfie_pkg::OP_SWAP, 4'h7, 2'h1);
    chk("swap acc", 8'h07, acc_o);
    chk("swap old", 8'h00, swap_data_o);
    chk("swap zero kept", 8'h01, zero_o);
    @(posedge mclk_i);
    ptr_wrap_i <= 1'b1;
    @(posedge mclk_i);
    ptr_wrap_i <= 1'b0;
    @(negedge mclk_i);
    chk("ovf on wrap", 8'h01, ovf_o);
    exec(ccfie_pkg::OP_PUSH, 4'h0, 2'h1);
    chk("rsp push", 8'h01, rsp_o);
    exec(ccfie_pkg::OP_LOAD, 4'h3, 2'h1);
    exec(ccfie_pkg::OP_ADD, 4'h0, 2'h1);
    chk("carry clear", 8'h00, carry_o);
    chk("zero clear", 8'h00, zero_o);
    exec(ccfie_pkg::OP_POP, 4'h0, 2'h1);
    chk("pop acc", 8'h07, acc_o);
    chk("pop carry", 8'h01, carry_o);
    chk("pop zero", 8'h01, zero_o);
    chk("pop ovf", 8'h01, ovf_o);
    chk("rsp pop", 8'h00, rsp_o);
    issue(ccfie_pkg::OP_POUT, 4'h5, 2'h1, t0);
    @(negedge mclk_i);
    for (i = 0; i < 20 && state_o !== 4'h8; i++) begin
      chk("port before s2 high", 8'h00, port_out_o);
      @(negedge mclk_i);
    end
    chk("port in s2 high", 8'h05, port_out_o);
    settle(1);
    @(posedge mclk_i);
    port_pin_i <= 4'ha;
    exec(ccfie_pkg::OP_PIN, 4'h0, 2'h1);
    chk("port read", 8'h0a, acc_o);
    chk("port read zero", 8'h00, zero_o);
    @(posedge mclk_i);
    port_pin_i <= 4'hf;
    issue(ccfie_pkg::OP_PIN, 4'h0, 2'h1, t0);
    // Short low on bit 0 that lands in the capture window after sync
    @(posedge mclk_i);
    port_pin_i <= 4'he;
    @(posedge mclk_i);
    port_pin_i <= 4'hf;
    settle(1);
    chk("glitch read", 8'h0e, acc_o);
    pulse(8'h08);
    repeat (30) @(negedge mclk_i);
    @(posedge mclk_i);
    chk("masked accepts", 8'h00, 8'(n_ack));
    exec(ccfie_pkg::OP_EI, 4'h0, 2'h1);
    chk("enable on", 8'h01, global_irq_enable_reg_o);
    wait_irq(3'h3);
    pulse(8'h01);
    wait_irq(3'h0);
    pulse(8'h24);
    repeat (20) @(negedge mclk_i);
    @(posedge mclk_i);
    chk("masked pair", 8'h02, 8'(n_ack));
    exec(ccfie_pkg::OP_RTI, 4'h0, 2'h1);
    wait_irq(3'h2);
    exec(ccfie_pkg::OP_EI, 4'h0, 2'h1);
    wait_irq(3'h5);
    exec(ccfie_pkg::OP_RTI, 4'h0, 2'h1);
    chk("enable by return", 8'h01, global_irq_enable_reg_o);
    exec(ccfie_pkg::OP_DI, 4'h0, 2'h1);
    chk("enable off", 8'h00, global_irq_enable_reg_o);
    @(posedge mclk_i);
    chk("accept count", 8'h04, 8'(n_ack));
    osc_rc_i <= 1'b1;
    wait_bnd();
    wait_bnd();
    period(8'h04);
    close_out();
  end
endmodule : ccfie_core_tb
